// file: sfc_sync.sv
// Summary of operation
// RULE1: All link bytes travel MSB first.
// RULE2: First eight bits after select form opcode.
// RULE3: Transaction starts at chip-select falling edge.
// RULE4: Unknown opcode: ignore input, output floats.
// RULE5: Sample input rising, drive output falling.
// RULE6: Master idles clock low (mode 0) or high (mode 3).
// RULE7: 06h sets write latch, 04h clears it.
// RULE8: 05h reads status, 01h writes status.
// RULE9: 03h normal read, 0Bh fast read. The code decodes both but drives no data and raises no O_OP_START for them.
// RULE10: 02h starts page program.
// RULE11: D7h sector, D8h block, C7h chip erase.
// RULE12: ABh, three dummies, then three ID bytes.
// RULE13: Program, erases, status write need write latch.
// RULE14: Write latch clear at power-up.
// RULE15: Write disable ignores write-protect pin.
// RULE16: Busy: only status read is accepted.
// RULE17: Status bit 0 shows busy.
// RULE18: Status bit 1 shows write latch.
// RULE19: Status bits 2-3 hold protect level.
// RULE20: Bits 4-6 zero; all ones while busy.
// RULE21: Status bit 7 enables write-protect pin.
// RULE22: Protect level locks blocks against writes.
// RULE23: Deselected: ignore input, output floats.
// RULE24: Pin low and bit 7 block status writes.
// RULE25: Write latch clears after write cycle.
// RULE26: Early deselect abandons instruction without effect.
// ============================================================
// Constants
package sfc_pkg;
	localparam int          CORE_CLK_MHZ = 100;
	localparam int          T_PROG_US    = 2000;
	localparam int          T_ERASE_US   = 40000;
	localparam int          T_SRWR_US    = 2000;
	localparam int          PROG_CYC     = T_PROG_US * CORE_CLK_MHZ;
	localparam int          ERASE_CYC    = T_ERASE_US * CORE_CLK_MHZ;
	localparam int          SRWR_CYC     = T_SRWR_US * CORE_CLK_MHZ;
	localparam int          BUSY_W       = 23;
	localparam int          CNT_W        = 16;
	localparam logic [15:0] CNT_ONE      = 16'h0001;
	localparam logic [15:0] CNT_OPC_LAST = 16'h0007;
	localparam logic [15:0] CNT_ARG_LO   = 16'h0008;
	localparam logic [15:0] CNT_ARG_HI   = 16'h001F;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;
	localparam logic [12:0] BYTE_ONE     = 13'h0001;
	localparam logic [12:0] BYTE_ID0     = 13'h0004;
	localparam logic [12:0] BYTE_ID1     = 13'h0005;
	localparam logic [12:0] BYTE_ID2     = 13'h0006;
	localparam logic [2:0]  BIT_ZERO     = 3'h0;
	localparam int          ADDR_MSB     = 16;
	localparam int          ST_BUSY_BIT  = 0;
	localparam int          ST_WEL_BIT   = 1;
	localparam int          ST_BP_LO     = 2;
	localparam int          ST_BP_HI     = 3;
	localparam int          ST_PROTECT_PIN_ENABLE_BIT  = 7;
	localparam logic [7:0]  ST_BUSY_VAL  = 8'hFF;
	localparam logic [2:0]  ST_RSVD_VAL  = 3'h0;
	// Identity bytes: values are arbitrary
	localparam logic [7:0]  ID_MAKER1    = 8'h5A;
	localparam logic [7:0]  ID_PART      = 8'h3C;
	localparam logic [7:0]  ID_MAKER2    = 8'hA5;
	localparam logic [7:0]  OPC_SET_WEL  = 8'h06;
	localparam logic [7:0]  OPC_CLR_WEL  = 8'h04;
	localparam logic [7:0]  OPC_SR_READ  = 8'h05;
	localparam logic [7:0]  OPC_SR_WRITE = 8'h01;
	localparam logic [7:0]  OPC_READ     = 8'h03;
	localparam logic [7:0]  OPC_FREAD    = 8'h0B;
	localparam logic [7:0]  OPC_PROG     = 8'h02;
	localparam logic [7:0]  OPC_SERASE   = 8'hD7;
	localparam logic [7:0]  OPC_BERASE   = 8'hD8;
	localparam logic [7:0]  OPC_CERASE   = 8'hC7;
	localparam logic [7:0]  OPC_IDENT    = 8'hAB;
	localparam logic [1:0]  PL_NONE      = 2'h0;
	localparam logic [1:0]  PL_QUARTER   = 2'h1;
	localparam logic [1:0]  PL_HALF      = 2'h2;
	localparam logic [1:0]  PL_ALL       = 2'h3;

	typedef enum logic [3:0] {
		K_NONE      = 4'h0,
		K_SET_WEL   = 4'h1,
		K_CLR_WEL   = 4'h2,
		K_SR_READ   = 4'h3,
		K_SR_WRITE  = 4'h4,
		K_READ      = 4'h5,
		K_FREAD     = 4'h6,
		K_PROG      = 4'h7,
		K_SERASE    = 4'h8,
		K_BERASE    = 4'h9,
		K_CERASE    = 4'hA,
		K_IDENT     = 4'hB
	} sfc_kind_t;

	function automatic sfc_kind_t sfc_op_kind(input logic [7:0] op);
		case (op)
			OPC_SET_WEL:  return K_SET_WEL;
			OPC_CLR_WEL:  return K_CLR_WEL;
			OPC_SR_READ:  return K_SR_READ;
			OPC_SR_WRITE: return K_SR_WRITE;
			OPC_READ:     return K_READ;
			OPC_FREAD:    return K_FREAD;
			OPC_PROG:     return K_PROG;
			OPC_SERASE:   return K_SERASE;
			OPC_BERASE:   return K_BERASE;
			OPC_CERASE:   return K_CERASE;
			OPC_IDENT:    return K_IDENT;
			default:      return K_NONE;
		endcase
	endfunction

	// Bytes a committing instruction needs, zero if it never commits
	function automatic logic [12:0] sfc_need(input sfc_kind_t k);
		case (k)
			K_SET_WEL, K_CLR_WEL, K_CERASE: return 13'h0001;
			K_SR_WRITE:                     return 13'h0002;
			K_SERASE, K_BERASE:             return 13'h0004;
			K_PROG:                         return 13'h0005;
			default:                        return 13'h0000;
		endcase
	endfunction

	function automatic logic sfc_is_write(input sfc_kind_t k);
		return (k == K_PROG) || (k == K_SERASE) || (k == K_BERASE) ||
		       (k == K_CERASE) || (k == K_SR_WRITE);
	endfunction
endpackage

// ============================================================
// Two-flop synchroniser
`timescale 1ns/1ps
module sfc_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= RST_VAL;
			o_q    <= RST_VAL;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule

// file: sfc_front_end.sv
`timescale 1ns/1ps
module sfc_front_end
	import sfc_pkg::*;
#(
	parameter int PROG_CYCLES  = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int SRWR_CYCLES  = SRWR_CYC
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_SCK,
	input  wire logic        I_CS_N,
	input  wire logic        I_SI,
	input  wire logic        I_WP_N,
	output logic             O_SO,
	output logic             O_SO_OE,
	output logic             O_BUSY,
	output logic             O_OP_START,
	output logic [3:0]       O_OP_KIND,
	output logic [23:0]      O_OP_ADDR
);
	// ============================================================
	// Declarations
	logic              rst_lk_q;
	logic              in_frame_q;
	logic              tog_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [7:0]        sh_q;
	logic [7:0]        op_q;
	logic [23:0]       arg_q;
	logic              dead_q;
	logic              wel_q;
	logic [1:0]        bp_q;
	logic              protect_pin_enable_q;
	logic              busy_q;
	logic [BUSY_W-1:0] tmr_q;
	logic [7:0]        snap_q;
	logic              seen_q;
	logic              cs_prev_q;
	logic              cs_s;
	logic              wp_s;
	logic              tog_s;

	// ============================================================
	// Link side: bit counting and capture on rising SCK
	wire              first     = !in_frame_q;
	wire              opc_end   = !first && (cnt_q == CNT_OPC_LAST);
	wire [7:0]        sh_d      = first ? {7'h00, I_SI} : {sh_q[6:0], I_SI};
	wire [6:0]        sh_lo     = sh_q[6:0];
	wire sfc_kind_t   nkind     = sfc_op_kind(sh_d);
	wire              arg_win   = !first && (cnt_q >= CNT_ARG_LO) && (cnt_q <= CNT_ARG_HI);
	wire              cnt_sat   = (cnt_q == CNT_MAX);
	wire [CNT_W-1:0]  cnt_inc   = cnt_sat ? cnt_q : cnt_q + CNT_ONE;
	wire [CNT_W-1:0]  cnt_d     = first ? CNT_ONE : (dead_q ? cnt_q : cnt_inc);
	wire              lock_busy = snap_q[ST_BUSY_BIT] && (nkind != K_SR_READ);
	wire              dead_d    = first ? 1'b0 :
	                              (opc_end ? ((nkind == K_NONE) || lock_busy) : dead_q);

	// Frame marker; deselect clears it at once
	always_ff @(posedge I_SCK or posedge I_CS_N) begin
		if (I_CS_N) begin
			in_frame_q <= 1'b0; // see RULE3 see RULE23
		end else begin
			in_frame_q <= 1'b1;
		end
	end

	// Captured words stay still while deselected, so the core reads them then
	// Idle-level changes of SCK between frames must not disturb them
	always_ff @(posedge I_SCK or posedge rst_lk_q) begin
		if (rst_lk_q) begin
			tog_q  <= 1'b0;
			cnt_q  <= '0;
			sh_q   <= 8'h00;
			op_q   <= 8'h00;
			arg_q  <= 24'h000000;
			dead_q <= 1'b1;
		end else if (!I_CS_N) begin // see RULE23
			tog_q  <= first ? ~tog_q : tog_q;
			cnt_q  <= cnt_d;
			dead_q <= dead_d; // see RULE4 see RULE16
			if (!dead_q || first) begin
				sh_q <= sh_d; // see RULE1 see RULE5
			end
			if (opc_end) begin
				op_q <= sh_d; // see RULE2
			end
			if (first) begin
				arg_q <= 24'h000000;
			end else if (arg_win && !dead_q) begin
				arg_q <= {arg_q[22:0], I_SI};
			end
		end
	end

	// ============================================================
	// Link side: serial output on falling SCK
	wire sfc_kind_t   okind    = sfc_op_kind(op_q);
	wire [12:0]       byte_idx = cnt_q[CNT_W-1:3];
	wire              rd_stat  = (okind == K_SR_READ) && (byte_idx >= BYTE_ONE);
	wire              rd_id    = (okind == K_IDENT) && (byte_idx >= BYTE_ID0) &&
	                             (byte_idx <= BYTE_ID2);
	wire [7:0]        id_byte  = (byte_idx == BYTE_ID0) ? ID_MAKER1 :
	                             ((byte_idx == BYTE_ID1) ? ID_PART : ID_MAKER2);
	wire [7:0]        out_byte = rd_stat ? snap_q : id_byte;
	wire              oe_d     = in_frame_q && !dead_q && (rd_stat || rd_id);
	wire              so_d     = out_byte[~cnt_q[2:0]];

	always_ff @(negedge I_SCK or posedge I_CS_N or posedge rst_lk_q) begin
		if (I_CS_N || rst_lk_q) begin
			O_SO    <= 1'b0;
			O_SO_OE <= 1'b0; // see RULE23
		end else begin
			O_SO    <= so_d;  // see RULE1 see RULE5 see RULE8 see RULE12
			O_SO_OE <= oe_d;  // see RULE4
		end
	end

	// ============================================================
	// Core side: crossings
	sfc_sync #(
		.W       (3),
		.RST_VAL (3'h6)
	) u_sync (
		.i_clk (I_CORE_CLK),
		.i_rst (I_RST),
		.i_d   ({I_CS_N, I_WP_N, tog_q}),
		.o_q   ({cs_s, wp_s, tog_s})
	);

	// ============================================================
	// Core side: commit decode at deselect
	wire sfc_kind_t   ckind     = sfc_op_kind(op_q);
	wire [12:0]       need      = sfc_need(ckind);
	wire              rise      = cs_s && !cs_prev_q;
	wire              new_frame = rise && (tog_s != seen_q);
	wire              aligned   = (cnt_q[2:0] == BIT_ZERO);
	wire              complete  = aligned && (need != 13'h0000) && (byte_idx >= need);
	wire              commit    = new_frame && !dead_q && complete && !busy_q;
	wire              hw_prot   = !wp_s && protect_pin_enable_q;
	wire              top_q     = arg_q[ADDR_MSB] && arg_q[ADDR_MSB-1];
	wire              locked    = (bp_q == PL_ALL) ||
	                              ((bp_q == PL_HALF) && arg_q[ADDR_MSB]) ||
	                              ((bp_q == PL_QUARTER) && top_q);
	wire              chip_lock = (bp_q != PL_NONE);
	wire              blocked   = (ckind == K_SR_WRITE) ? hw_prot :
	                              ((ckind == K_CERASE) ? chip_lock : locked);
	wire              is_wr     = sfc_is_write(ckind);
	wire              start     = commit && is_wr && wel_q && !blocked;
	wire [BUSY_W-1:0] dur       = (ckind == K_PROG) ? BUSY_W'(PROG_CYCLES - 1) :
	                              ((ckind == K_SR_WRITE) ? BUSY_W'(SRWR_CYCLES - 1) :
	                              BUSY_W'(ERASE_CYCLES - 1));
	wire              cyc_end   = busy_q && (tmr_q == '0);
	wire [7:0]        st_word   = busy_q ? ST_BUSY_VAL :
	                              {protect_pin_enable_q, ST_RSVD_VAL, bp_q, wel_q, 1'b0};

	// ============================================================
	// Core side: status, write latch and write cycle
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			rst_lk_q   <= 1'b1;
			cs_prev_q  <= 1'b1;
			seen_q     <= 1'b0;
			wel_q      <= 1'b0; // see RULE14
			bp_q       <= PL_NONE;
			protect_pin_enable_q     <= 1'b0;
			busy_q     <= 1'b0;
			tmr_q      <= '0;
			snap_q     <= 8'h00;
			O_BUSY     <= 1'b0;
			O_OP_START <= 1'b0;
			O_OP_KIND  <= K_NONE;
			O_OP_ADDR  <= 24'h000000;
		end else begin
			rst_lk_q   <= 1'b0;
			cs_prev_q  <= cs_s;
			O_BUSY     <= busy_q;
			O_OP_START <= start; // see RULE10 see RULE11
			if (rise) begin
				seen_q <= tog_s; // see RULE26
			end
			if (cs_s) begin
				snap_q <= st_word; // see RULE17 see RULE18 see RULE20
			end
			if (start) begin
				O_OP_KIND <= ckind;
				O_OP_ADDR <= arg_q;
			end
			if (commit && (ckind == K_SET_WEL)) begin
				wel_q <= 1'b1; // see RULE7
			end else if (commit && (ckind == K_CLR_WEL)) begin
				wel_q <= 1'b0; // see RULE7 see RULE15
			end else if (cyc_end) begin
				wel_q <= 1'b0; // see RULE25
			end
			if (start && (ckind == K_SR_WRITE)) begin
				bp_q   <= arg_q[ST_BP_HI:ST_BP_LO]; // see RULE19 see RULE21 see RULE24
				protect_pin_enable_q <= arg_q[ST_PROTECT_PIN_ENABLE_BIT];
			end
			if (start) begin
				busy_q <= 1'b1; // see RULE13 see RULE22
				tmr_q  <= dur;
			end else if (cyc_end) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				tmr_q  <= tmr_q - 1'b1;
			end
		end
	end

	// ============================================================
	// Checks: link side
	sequence s_opc_end;
		opc_end && !dead_q;
	endsequence

	property p_opc_msb;
		@(posedge I_SCK) disable iff (I_CS_N || rst_lk_q)
		s_opc_end |=> (op_q[7:1] == $past(sh_lo)) && (op_q[0] == $past(I_SI));
	endproperty
	a_opc_msb: assert property (p_opc_msb) else $error("opcode not MSB first"); // see RULE2

	property p_bad_opc;
		@(posedge I_SCK) disable iff (I_CS_N || rst_lk_q)
		s_opc_end ##0 (nkind == K_NONE) |=> dead_q [*2];
	endproperty
	a_bad_opc: assert property (p_bad_opc) else $error("bad opcode accepted"); // see RULE4

	property p_busy_lock;
		@(posedge I_SCK) disable iff (I_CS_N || rst_lk_q)
		s_opc_end ##0 lock_busy |=> dead_q ##1 (dead_q && $stable(cnt_q));
	endproperty
	a_busy_lock: assert property (p_busy_lock) else $error("busy lockout failed"); // see RULE16

	property p_dead_quiet;
		@(negedge I_SCK) disable iff (I_CS_N || rst_lk_q)
		dead_q |=> !O_SO_OE;
	endproperty
	a_dead_quiet: assert property (p_dead_quiet) else $error("output driven when dead"); // see RULE4

	// ============================================================
	// Checks: core side
	sequence s_wr_go;
		start ##1 busy_q;
	endsequence

	property p_set_wel;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		commit && (ckind == K_SET_WEL) |=> wel_q;
	endproperty
	a_set_wel: assert property (p_set_wel) else $error("write latch not set"); // see RULE7

	property p_clr_wel;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		commit && (ckind == K_CLR_WEL) |=> !wel_q;
	endproperty
	a_clr_wel: assert property (p_clr_wel) else $error("write latch not cleared"); // see RULE15

	property p_no_wel;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		commit && is_wr && !wel_q |=> !busy_q && $stable(bp_q);
	endproperty
	a_no_wel: assert property (p_no_wel) else $error("write ran without latch"); // see RULE13

	property p_hw_prot;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		commit && (ckind == K_SR_WRITE) && hw_prot |=> $stable(bp_q) && $stable(protect_pin_enable_q);
	endproperty
	a_hw_prot: assert property (p_hw_prot) else $error("protected status written"); // see RULE24

	property p_locked;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		commit && (ckind == K_PROG) && locked |=> !busy_q;
	endproperty
	a_locked: assert property (p_locked) else $error("locked block written"); // see RULE22

	property p_cycle_end;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		s_wr_go |-> wel_q ##1 busy_q;
	endproperty
	a_cycle_end: assert property (p_cycle_end) else $error("write cycle too short"); // see RULE25

	property p_wel_drop;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		$fell(busy_q) |-> !wel_q;
	endproperty
	a_wel_drop: assert property (p_wel_drop) else $error("latch left set"); // see RULE25

	property p_busy_word;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		busy_q && cs_s |=> (snap_q == ST_BUSY_VAL);
	endproperty
	a_busy_word: assert property (p_busy_word) else $error("busy status wrong"); // see RULE20

	property p_ready_word;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		!busy_q && cs_s |=> !snap_q[ST_BUSY_BIT] && (snap_q[ST_WEL_BIT] == $past(wel_q));
	endproperty
	a_ready_word: assert property (p_ready_word) else $error("ready status wrong"); // see RULE17
endmodule

// file: sfc_spi_master.sv
`timescale 1ns/1ps
// ============================================================
// Behavioural SPI master, modes 0 and 3
module sfc_spi_master (
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si,
	input  wire logic i_so,
	input  wire logic i_so_oe
);
	logic [7:0] txq[$];
	logic [7:0] rx_b;
	logic [7:0] sh;
	int         nbit;
	event       rx_ev;

	initial begin
		o_sck  = 1'b0;
		o_cs_n = 1'b1;
		o_si   = 1'b0;
		rx_b   = 8'h00;
		sh     = 8'h00;
		nbit   = 0;
	end

	// ============================================================
	// One bit: drive on fall, sample just before rise
	task automatic bit_x(input logic v);
		o_sck = 1'b0;
		o_si  = v;
		#40;
		if (i_so_oe === 1'b1) begin
			sh   = {sh[6:0], i_so};
			nbit = nbit + 1;
		end
		if (nbit == 8) begin
			rx_b = sh;
			nbit = 0;
			-> rx_ev;
		end
		o_sck = 1'b1;
		#40;
	endtask

	// ============================================================
	// Whole frame from txq, then xb random trailing bits
	task automatic send(input logic m3, input int xb);
		logic [7:0] b;
		o_sck = m3;
		#43;
		nbit   = 0;
		o_cs_n = 1'b0;
		#50;
		while (txq.size() > 0) begin
			b = txq.pop_front();
			for (int i = 7; i >= 0; i--) bit_x(b[i]);
		end
		for (int i = 0; i < xb; i++) bit_x(1'($urandom));
		o_sck = m3;
		#40;
		o_cs_n = 1'b1;
		o_si   = ~o_si;
		#40;
		o_sck  = m3;
	endtask
endmodule

// file: spi_flash_command_front_end_bench.sv
`timescale 1ns/1ps
module spi_flash_command_front_end_bench;
	import sfc_pkg::*;
	logic        I_CORE_CLK;
	logic        I_RST;
	logic        I_WP_N;
	logic        sck;
	logic        cs_n;
	logic        si;
	logic        O_SO;
	logic        O_SO_OE;
	logic        O_BUSY;
	logic        O_OP_START;
	logic [3:0]  O_OP_KIND;
	logic [23:0] O_OP_ADDR;
	logic        mode3;
	logic [7:0]  exp_b[$];
	logic [27:0] exp_op[$];
	logic [23:0] a;
	int          bad_count;
	int          comparisons;
	int          cyc;

	sfc_front_end #(.PROG_CYCLES(2000), .ERASE_CYCLES(3000), .SRWR_CYCLES(1500)) dut (
		.I_CORE_CLK (I_CORE_CLK),
		.I_RST      (I_RST),
		.I_SCK      (sck),
		.I_CS_N     (cs_n),
		.I_SI       (si),
		.I_WP_N     (I_WP_N),
		.O_SO       (O_SO),
		.O_SO_OE    (O_SO_OE),
		.O_BUSY     (O_BUSY),
		.O_OP_START (O_OP_START),
		.O_OP_KIND  (O_OP_KIND),
		.O_OP_ADDR  (O_OP_ADDR)
	);

	sfc_spi_master m (
		.o_sck   (sck),
		.o_cs_n  (cs_n),
		.o_si    (si),
		.i_so    (O_SO),
		.i_so_oe (O_SO_OE)
	);

	initial begin
		I_CORE_CLK = 1'b0;
		forever #5 I_CORE_CLK = ~I_CORE_CLK;
	end

	// ============================================================
	// Checking
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error: %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		check("pending notes", exp_b.size() + exp_op.size(), 32'h0);
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(m.rx_ev) begin
		if (exp_b.size() == 0)
			check("stray so byte", {24'h0, m.rx_b}, 32'hFFFF_FFFF);
		else
			check("so byte", {24'h0, m.rx_b}, {24'h0, exp_b.pop_front()});
	end

	always @(posedge I_CORE_CLK) begin : op_mon
		logic [27:0] e;
		logic [31:0] msk;
		cyc++;
		if (cyc == 100000) begin
			bad_count++;
			$display("Error: timeout");
			finish_test();
		end
		if (cs_n === 1'b1 && O_SO_OE !== 1'b0)
			check("oe while deselected", {31'h0, O_SO_OE}, 32'h0);
		if (O_OP_START === 1'b1) begin
			if (exp_op.size() == 0) begin
				check("stray op", {28'h0, O_OP_KIND}, 32'hFFFF_FFFF);
			end else begin
				e   = exp_op.pop_front();
				msk = (e[27:24] == K_SR_WRITE) ? 32'h0000_00FF : 32'h00FF_FFFF;
				check("op kind", {28'h0, O_OP_KIND}, {28'h0, e[27:24]});
				check("op addr", {8'h0, O_OP_ADDR} & msk, {8'h0, e[23:0]} & msk);
			end
		end
	end

	// ============================================================
	// Drivers
	task automatic fr(input int n, input logic [39:0] v, input int xb);
		@(posedge I_CORE_CLK);
		#1;
		for (int i = 0; i < n; i++) m.txq.push_back(v[39 - 8 * i -: 8]);
		m.send(mode3, xb);
		mode3 = ~mode3;
		repeat (20) @(posedge I_CORE_CLK);
		#1;
	endtask

	task automatic status_read_cmd(input logic [7:0] e);
		exp_b.push_back(e);
		exp_b.push_back(e);
		fr(3, {OPC_SR_READ, 32'($urandom)}, 0);
	endtask

	task automatic wait_lvl(input logic lvl);
		int k;
		k = 0;
		while (O_BUSY !== lvl && k < 6000) begin
			@(posedge I_CORE_CLK);
			k++;
		end
		#1;
		check("busy level", {31'h0, O_BUSY}, {31'h0, lvl});
	endtask

	task automatic wr(input int n, input logic [39:0] v, input logic go, input logic [27:0] e);
		fr(1, {OPC_SET_WEL, 32'h0}, 0);
		if (go)
			exp_op.push_back(e);
		fr(n, v, 0);
		if (go) begin
			wait_lvl(1'b1);
			status_read_cmd(ST_BUSY_VAL);
			fr(1, {OPC_SET_WEL, 32'h0}, 16);
			wait_lvl(1'b0);
		end
	endtask

	// ============================================================
	// Main sequence
	initial begin
		bad_count   = 0;
		comparisons = 0;
		cyc         = 0;
		mode3       = 1'b0;
		I_RST       = 1'b1;
		I_WP_N      = 1'b1;
		a           = 24'($urandom(32'h77F2E3D4));
		repeat (5) @(posedge I_CORE_CLK);
		#1 I_RST = 1'b0;
		repeat (5) @(posedge I_CORE_CLK);
		status_read_cmd(8'h00);
		status_read_cmd(8'h00);
		$display("test reset status done");
		fr(1, {OPC_SET_WEL, 32'h0}, 0);
		status_read_cmd(8'h02);
		fr(1, {OPC_CLR_WEL, 32'h0}, 3);
		status_read_cmd(8'h02);
		I_WP_N = 1'b0;
		fr(1, {OPC_CLR_WEL, 32'h0}, 0);
		status_read_cmd(8'h00);
		I_WP_N = 1'b1;
		$display("test write latch done");
		exp_b.push_back(ID_MAKER1);
		exp_b.push_back(ID_PART);
		exp_b.push_back(ID_MAKER2);
		fr(4, {OPC_IDENT, 32'($urandom)}, 32);
		for (int i = 0; i < 4; i++)
			fr(4, {8'({8'h9F, OPC_READ, OPC_FREAD, 8'h00} >> (24 - 8 * i)), 32'($urandom)}, 16);
		$display("test identify and unknown done");
		fr(5, {OPC_PROG, 24'h000100, 8'($urandom)}, 0);
		status_read_cmd(8'h00);
		wr(2, {OPC_SR_WRITE, 8'h8C, 24'h0}, 1'b1, {K_SR_WRITE, 24'h00008C});
		status_read_cmd(8'h8C);
		I_WP_N = 1'b0;
		wr(2, {OPC_SR_WRITE, 8'h00, 24'h0}, 1'b0, 28'h0);
		status_read_cmd(8'h8E);
		I_WP_N = 1'b1;
		wr(2, {OPC_SR_WRITE, 8'h04, 24'h0}, 1'b1, {K_SR_WRITE, 24'h000004});
		status_read_cmd(8'h04);
		$display("test status write done");
		wr(5, {OPC_PROG, 24'h018000, 8'($urandom)}, 1'b0, 28'h0);
		status_read_cmd(8'h06);
		wr(5, {OPC_PROG, 24'h017FFF, 8'($urandom)}, 1'b1, {K_PROG, 24'h017FFF});
		wr(1, {OPC_CERASE, 32'h0}, 1'b0, 28'h0);
		wr(2, {OPC_SR_WRITE, 8'h00, 24'h0}, 1'b1, {K_SR_WRITE, 24'h000000});
		fr(1, {OPC_SET_WEL, 32'h0}, 0);
		fr(2, {OPC_SERASE, 32'($urandom)}, 0);
		status_read_cmd(8'h02);
		$display("test protection done");
		a = 24'($urandom);
		wr(4, {OPC_SERASE, a, 8'h0}, 1'b1, {K_SERASE, a});
		a = 24'($urandom);
		wr(4, {OPC_BERASE, a, 8'h0}, 1'b1, {K_BERASE, a});
		wr(1, {OPC_CERASE, 32'h0}, 1'b1, {K_CERASE, 24'h0});
		status_read_cmd(8'h00);
		$display("test erase done");
		finish_test();
	end
endmodule
